// ==== verilog/sdt_top.sv ====
// display timing generator with pixel fifo and axi4-lite registers
//
// Function
// - rgb 16/18/24 bit placement on output bus
// - ycc8 alternates luma/chroma, ycc16 splits bytes
// - pixel clock, hsync aux2, vsync aux3, tear aux1
// - pixel spans clocks_per_pixel interface clocks
// - line length counted in interface clocks
// - hsync width in half base clocks
// - leading horizontal blank before active pixels
// - trailing horizontal blank fills rest of line
// - frame height counted in lines with blanking
// - vsync width in half base clocks
// - leading vertical blank lines before active
// - trailing vertical blank fills rest of frame
// - clock edges placed by fall/rise offsets
// - edge position is ceil of twice offset/divider
// - clock low fall minus rise, high rest
// - each control pin has own delay offset
//
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps

// ****************************************************************
// pixel fifo
// ****************************************************************
module sdt_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ff;
  logic [AW-1:0]    rd_ff;
  logic [AW:0]      cnt_ff;
  logic [AW:0]      nxt_cnt;
  logic             push;
  logic             pop;

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_valid = cnt_ff != '0;
  assign out_data  = mem_ff[rd_ff];

  // occupancy; ready is registered so back-pressure reaches the source
  always_comb begin
    nxt_cnt = cnt_ff;
    if (push && !pop) begin
      nxt_cnt = cnt_ff + 1'b1;
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff   <= '0;
      in_ready <= 1'b0;
    end else begin
      cnt_ff   <= nxt_cnt;
      in_ready <= nxt_cnt < DEPTH_C;
    end
  end

  // pointers wrap at depth
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data;
    end
  end
endmodule

// ****************************************************************
// timing generator top
// ****************************************************************
module sdt_top #(
  parameter int FIFO_DEPTH = 4,
  parameter int OFS_MAX    = 16
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // pixel stream in
  input  wire logic        pix_valid,
  output logic             pix_ready,
  input  wire logic [23:0] pix_data,
  // display pins
  output logic [23:0]      pixel_out_bus,
  output logic             pixel_clock_out,
  output logic             aux_pin_one,
  output logic             aux_pin_two,
  output logic             aux_pin_three
);

  // ****************************************************************
  // registers
  // ****************************************************************
  logic                enable_ff;
  sdt_pkg::sdt_mode_e  mode_ff;
  logic                tear_en_ff;
  logic [11:0]         htotal_ff, hlead_ff, hact_ff;
  logic [11:0]         vtotal_ff, vlead_ff, vact_ff;
  logic [15:0]         hsync_w_ff, vsync_w_ff;
  logic [7:0]          div_ff, cpp_ff, fall_ofs_ff, rise_ofs_ff;
  logic [3:0]          ofs_ff [3];
  logic                underrun_ff;

  // timing state
  logic [8:0]  ph_ff;
  logic [11:0] h_ff, v_ff;
  logic [7:0]  comp_ff;
  logic [15:0] hs_cnt_ff, vs_cnt_ff;
  logic [2:0]  ctl_ff;

  // fifo head
  logic        fifo_valid;
  logic [23:0] fifo_data;
  logic        pop;

  // ****************************************************************
  // interface clock phase and edges
  // ****************************************************************
  logic [7:0]  div_eff, cpp_eff;
  logic [8:0]  per_w, fall_pos, rise_pos;
  logic [9:0]  num_fall, num_rise;
  logic        tick, line_end, frame_end, act_w, last_comp, pclk_raw;
  logic [12:0] h_stop, v_stop;

  assign div_eff = (div_ff == 8'h00) ? 8'h01 : div_ff;
  assign cpp_eff = (cpp_ff == 8'h00) ? 8'h01 : cpp_ff;
  // period counted in half base clocks, one aclk each
  assign per_w   = {div_eff, 1'b0};
  // edge slot rounds upward
  assign num_fall = {1'b0, fall_ofs_ff, 1'b0} + {2'h0, div_eff} - 10'h001;
  assign num_rise = {1'b0, rise_ofs_ff, 1'b0} + {2'h0, div_eff} - 10'h001;
  assign fall_pos = 9'(num_fall / {2'h0, div_eff});
  assign rise_pos = 9'(num_rise / {2'h0, div_eff});
  assign tick     = ph_ff == per_w - 9'h001;
  // low between rise and fall slot, high for the rest of the period
  assign pclk_raw = !(ph_ff >= rise_pos && ph_ff < fall_pos);

  // phase inside one interface clock
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable_ff) begin
      ph_ff <= '0;
    end else begin
      ph_ff <= tick ? 9'h000 : ph_ff + 9'h001;
    end
  end

  // ****************************************************************
  // line and frame counters
  // ****************************************************************
  assign line_end  = tick && (h_ff >= htotal_ff - 12'h001);
  assign frame_end = line_end && (v_ff >= vtotal_ff - 12'h001);
  assign h_stop    = {1'b0, hlead_ff} + {1'b0, hact_ff};
  assign v_stop    = {1'b0, vlead_ff} + {1'b0, vact_ff};
  // trailing blank is whatever remains after lead plus active
  assign act_w = enable_ff
              && h_ff >= hlead_ff && {1'b0, h_ff} < h_stop
              && v_ff >= vlead_ff && {1'b0, v_ff} < v_stop;
  assign last_comp = comp_ff >= cpp_eff - 8'h01;

  always_ff @(posedge aclk) begin
    if (!aresetn || !enable_ff) begin
      h_ff <= '0;
      v_ff <= '0;
    end else if (tick) begin
      h_ff <= line_end ? 12'h000 : h_ff + 12'h001;
      if (frame_end) begin
        v_ff <= 12'h000;
      end else if (line_end) begin
        v_ff <= v_ff + 12'h001;
      end
    end
  end

  // component index within a pixel
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable_ff) begin
      comp_ff <= '0;
    end else if (tick) begin
      comp_ff <= (!act_w || last_comp) ? 8'h00 : comp_ff + 8'h01;
    end
  end

  // one fifo word per pixel, popped on its last component
  assign pop = tick && act_w && last_comp && fifo_valid;

  // ****************************************************************
  // sync pulse widths, in aclk = half base clock
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable_ff || line_end) begin
      hs_cnt_ff <= '0;
    end else if (hs_cnt_ff != 16'hffff) begin
      hs_cnt_ff <= hs_cnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !enable_ff || frame_end) begin
      vs_cnt_ff <= '0;
    end else if (vs_cnt_ff != 16'hffff) begin
      vs_cnt_ff <= vs_cnt_ff + 16'h0001;
    end
  end

  // raw controls: bit0 hsync, bit1 vsync, bit2 tear (vertical blank)
  assign ctl_ff[0] = enable_ff && hs_cnt_ff < hsync_w_ff;
  assign ctl_ff[1] = enable_ff && vs_cnt_ff < vsync_w_ff;
  assign ctl_ff[2] = enable_ff && tear_en_ff
                  && !(v_ff >= vlead_ff && {1'b0, v_ff} < v_stop);

  // ****************************************************************
  // per-pin control delay
  // ****************************************************************
  logic [OFS_MAX-2:0] line_ff [3];
  logic [2:0]         ctl_out_ff;

  for (genvar i = 0; i < 3; i++) begin : g_ctl
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        line_ff[i]    <= '0;
        ctl_out_ff[i] <= 1'b0;
      end else begin
        line_ff[i]    <= {line_ff[i][OFS_MAX-3:0], ctl_ff[i]};
        // each pin picks its own tap
        ctl_out_ff[i] <= (ofs_ff[i] == 4'h0) ? ctl_ff[i]
                         : line_ff[i][ofs_ff[i] - 4'h1];
      end
    end
  end

  // ****************************************************************
  // data mapping and pins
  // ****************************************************************
  function automatic logic [23:0] map_pix(sdt_pkg::sdt_mode_e m, logic [23:0] d, logic odd);
    case (m)
      sdt_pkg::SDT_RGB16: map_pix = {8'h00, d[23:19], d[15:10], d[7:3]};
      sdt_pkg::SDT_RGB18: map_pix = {6'h00, d[23:18], d[15:10], d[7:2]};
      sdt_pkg::SDT_YCC8:  map_pix = {16'h0000, odd ? d[15:8] : d[7:0]};
      sdt_pkg::SDT_YCC16: map_pix = {8'h00, d[15:8], d[7:0]};
      default:            map_pix = d;
    endcase
  endfunction

  // blanking or starved fifo shows zeros
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pixel_out_bus <= '0;
    end else begin
      pixel_out_bus <= (act_w && fifo_valid)
                       ? map_pix(mode_ff, fifo_data, comp_ff[0]) : 24'h000000;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pixel_clock_out <= 1'b0;
      aux_pin_one     <= 1'b0;
      aux_pin_two     <= 1'b0;
      aux_pin_three   <= 1'b0;
    end else begin
      pixel_clock_out <= enable_ff && pclk_raw;
      aux_pin_one     <= ctl_out_ff[2];
      aux_pin_two     <= ctl_out_ff[0];
      aux_pin_three   <= ctl_out_ff[1];
    end
  end

  sdt_fifo #(
    .WIDTH (24),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (pix_valid),
    .in_ready  (pix_ready),
    .in_data   (pix_data),
    .out_valid (fifo_valid),
    .out_ready (pop),
    .out_data  (fifo_data)
  );

  // ****************************************************************
  // axi4-lite slave
  // ****************************************************************
  logic        aw_hold_ff, w_hold_ff, do_wr, wr_hit;
  logic [7:0]  awaddr_ff;
  logic [31:0] wdata_ff, merged, cur_val;
  logic [3:0]  wstrb_ff;
  logic        clr_undr;

  function automatic logic [31:0] rd_val(logic [7:0] a);
    case (a)
      sdt_pkg::ADDR_CTRL:   rd_val = {27'h0, tear_en_ff, mode_ff, enable_ff};
      sdt_pkg::ADDR_HTOTAL: rd_val = {20'h0, htotal_ff};
      sdt_pkg::ADDR_HSYNC:  rd_val = {16'h0, hsync_w_ff};
      sdt_pkg::ADDR_HLEAD:  rd_val = {20'h0, hlead_ff};
      sdt_pkg::ADDR_HACT:   rd_val = {20'h0, hact_ff};
      sdt_pkg::ADDR_VTOTAL: rd_val = {20'h0, vtotal_ff};
      sdt_pkg::ADDR_VSYNC:  rd_val = {16'h0, vsync_w_ff};
      sdt_pkg::ADDR_VLEAD:  rd_val = {20'h0, vlead_ff};
      sdt_pkg::ADDR_VACT:   rd_val = {20'h0, vact_ff};
      sdt_pkg::ADDR_CLKDIV: rd_val = {16'h0, cpp_ff, div_ff};
      sdt_pkg::ADDR_EDGE:   rd_val = {16'h0, rise_ofs_ff, fall_ofs_ff};
      sdt_pkg::ADDR_CTLOFS: rd_val = {20'h0, ofs_ff[2], ofs_ff[1], ofs_ff[0]};
      sdt_pkg::ADDR_STATUS: rd_val = {underrun_ff, act_w, 2'h0, v_ff, 4'h0, h_ff};
      default:              rd_val = 32'h0;
    endcase
  endfunction

  function automatic logic mapped(logic [7:0] a);
    mapped = a[1:0] == 2'h0 && a <= sdt_pkg::ADDR_STATUS;
  endfunction

  assign do_wr  = aw_hold_ff && w_hold_ff && !s_axi_bvalid;
  assign wr_hit = do_wr && mapped(awaddr_ff);
  // byte lanes merge over the current contents
  assign cur_val = rd_val(awaddr_ff);
  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign merged[8*b +: 8] = wstrb_ff[b] ? wdata_ff[8*b +: 8] : cur_val[8*b +: 8];
  end
  assign clr_undr = wr_hit && awaddr_ff == sdt_pkg::ADDR_STATUS
                 && wstrb_ff[3] && wdata_ff[sdt_pkg::STAT_UNDR_BIT];

  // address and data taken in either order, response after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff    <= 1'b0;
      w_hold_ff     <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= sdt_pkg::RESP_OKAY;
      awaddr_ff     <= '0;
      wdata_ff      <= '0;
      wstrb_ff      <= '0;
    end else begin
      s_axi_awready <= !aw_hold_ff && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_hold_ff && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_ff <= 1'b1;
        awaddr_ff  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata;
        wstrb_ff  <= s_axi_wstrb;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(awaddr_ff) ? sdt_pkg::RESP_OKAY : sdt_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_hold_ff   <= 1'b0;
        w_hold_ff    <= 1'b0;
      end
    end
  end

  // register writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_ff   <= 1'b0;
      mode_ff     <= sdt_pkg::SDT_RGB24;
      tear_en_ff  <= 1'b0;
      htotal_ff   <= sdt_pkg::HTOTAL_RST;
      hsync_w_ff  <= sdt_pkg::HSYNC_RST;
      hlead_ff    <= sdt_pkg::HLEAD_RST;
      hact_ff     <= sdt_pkg::HACT_RST;
      vtotal_ff   <= sdt_pkg::VTOTAL_RST;
      vsync_w_ff  <= sdt_pkg::VSYNC_RST;
      vlead_ff    <= sdt_pkg::VLEAD_RST;
      vact_ff     <= sdt_pkg::VACT_RST;
      div_ff      <= sdt_pkg::DIV_RST;
      cpp_ff      <= sdt_pkg::CPP_RST;
      fall_ofs_ff <= sdt_pkg::FALL_RST;
      rise_ofs_ff <= sdt_pkg::RISE_RST;
      ofs_ff      <= '{default: 4'h0};
    end else if (wr_hit) begin
      case (awaddr_ff)
        sdt_pkg::ADDR_CTRL: begin
          enable_ff  <= merged[sdt_pkg::CTRL_EN_BIT];
          mode_ff    <= sdt_pkg::sdt_mode_e'(merged[sdt_pkg::CTRL_MODE_LSB +: 3]);
          tear_en_ff <= merged[sdt_pkg::CTRL_TEAR_BIT];
        end
        sdt_pkg::ADDR_HTOTAL: htotal_ff  <= merged[11:0];
        sdt_pkg::ADDR_HSYNC:  hsync_w_ff <= merged[15:0];
        sdt_pkg::ADDR_HLEAD:  hlead_ff   <= merged[11:0];
        sdt_pkg::ADDR_HACT:   hact_ff    <= merged[11:0];
        sdt_pkg::ADDR_VTOTAL: vtotal_ff  <= merged[11:0];
        sdt_pkg::ADDR_VSYNC:  vsync_w_ff <= merged[15:0];
        sdt_pkg::ADDR_VLEAD:  vlead_ff   <= merged[11:0];
        sdt_pkg::ADDR_VACT:   vact_ff    <= merged[11:0];
        sdt_pkg::ADDR_CLKDIV: begin
          div_ff <= merged[7:0];
          cpp_ff <= merged[15:8];
        end
        sdt_pkg::ADDR_EDGE: begin
          fall_ofs_ff <= merged[7:0];
          rise_ofs_ff <= merged[15:8];
        end
        sdt_pkg::ADDR_CTLOFS: begin
          ofs_ff[0] <= merged[3:0];
          ofs_ff[1] <= merged[7:4];
          ofs_ff[2] <= merged[11:8];
        end
        default: ;
      endcase
    end
  end

  // starvation flag; a new event beats a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      underrun_ff <= 1'b0;
    end else if (tick && act_w && !fifo_valid) begin
      underrun_ff <= 1'b1;
    end else if (clr_undr) begin
      underrun_ff <= 1'b0;
    end
  end

  // read channel, one cycle from address to data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= sdt_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= mapped(s_axi_araddr) ? rd_val(s_axi_araddr) : 32'h0;
      s_axi_rresp   <= mapped(s_axi_araddr) ? sdt_pkg::RESP_OKAY : sdt_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  h_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn)
    line_end && enable_ff |=> h_ff == 12'h000)
    else $error("line counter did not wrap");
  v_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
    line_end && !frame_end && enable_ff |=> v_ff == $past(v_ff) + 12'h001)
    else $error("line counter did not advance");
  blank_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !act_w |=> pixel_out_bus == 24'h000000)
    else $error("data driven during blanking");
  rgb16_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
    act_w && fifo_valid && mode_ff == sdt_pkg::SDT_RGB16
    |=> pixel_out_bus[15:11] == $past(fifo_data[23:19]) && pixel_out_bus[23:16] == 8'h00)
    else $error("rgb16 red misplaced");
  ycc16_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
    act_w && fifo_valid && mode_ff == sdt_pkg::SDT_YCC16
    |=> pixel_out_bus[15:8] == $past(fifo_data[15:8]))
    else $error("ycc16 luma misplaced");
  pop_last_a: assert property (@(posedge aclk) disable iff (!aresetn)
    pop |-> comp_ff == cpp_eff - 8'h01 && h_ff >= hlead_ff)
    else $error("pixel consumed before its last component");
  hs_width_a: assert property (@(posedge aclk) disable iff (!aresetn)
    line_end && enable_ff && hsync_w_ff == 16'h0002 |=> ctl_ff[0] ##1 ctl_ff[0] ##1 !ctl_ff[0])
    else $error("hsync width wrong");
  pclk_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
    enable_ff && ph_ff >= rise_pos && ph_ff < fall_pos |=> !pixel_clock_out)
    else $error("pixel clock high inside low window");
endmodule

// ==== verilog/sdt_pkg.sv ====
// constants shared by the synchronous display timing generator
package sdt_pkg;

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_HTOTAL = 8'h04;
  localparam logic [7:0] ADDR_HSYNC  = 8'h08;
  localparam logic [7:0] ADDR_HLEAD  = 8'h0c;
  localparam logic [7:0] ADDR_HACT   = 8'h10;
  localparam logic [7:0] ADDR_VTOTAL = 8'h14;
  localparam logic [7:0] ADDR_VSYNC  = 8'h18;
  localparam logic [7:0] ADDR_VLEAD  = 8'h1c;
  localparam logic [7:0] ADDR_VACT   = 8'h20;
  localparam logic [7:0] ADDR_CLKDIV = 8'h24;
  localparam logic [7:0] ADDR_EDGE   = 8'h28;
  localparam logic [7:0] ADDR_CTLOFS = 8'h2c;
  localparam logic [7:0] ADDR_STATUS = 8'h30;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_TEAR_BIT = 4;
  localparam int STAT_UNDR_BIT = 31;
  localparam int STAT_ACT_BIT  = 30;
  localparam int STAT_V_LSB    = 16;

  // ****************************************************************
  // output data layouts
  // ****************************************************************
  typedef enum logic [2:0] {
    SDT_RGB16,
    SDT_RGB18,
    SDT_RGB24,
    SDT_YCC8,
    SDT_YCC16
  } sdt_mode_e;

  // ****************************************************************
  // reset values and response codes
  // ****************************************************************
  localparam logic [11:0] HTOTAL_RST = 12'h320;
  localparam logic [15:0] HSYNC_RST  = 16'h00c0;
  localparam logic [11:0] HLEAD_RST  = 12'h090;
  localparam logic [11:0] HACT_RST   = 12'h280;
  localparam logic [11:0] VTOTAL_RST = 12'h20d;
  localparam logic [15:0] VSYNC_RST  = 16'h0640;
  localparam logic [11:0] VLEAD_RST  = 12'h023;
  localparam logic [11:0] VACT_RST   = 12'h1e0;
  localparam logic [7:0]  DIV_RST    = 8'h01;
  localparam logic [7:0]  CPP_RST    = 8'h01;
  localparam logic [7:0]  FALL_RST   = 8'h01;
  localparam logic [7:0]  RISE_RST   = 8'h00;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage

// ==== verification/sdt_panel.sv ====
// panel model that measures line, frame, clock and active-data figures
`timescale 1ns/100ps
module sdt_panel (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // display pins
  input  wire logic        hsync,
  input  wire logic        vsync,
  input  wire logic        pclk,
  input  wire logic [23:0] data,
  // measurements
  output logic [15:0]      line_len_ff,
  output logic [15:0]      frame_lines_ff,
  output logic [15:0]      low_len_ff,
  output logic [15:0]      act_cnt_ff
);
  logic [15:0] h_cnt_ff, l_cnt_ff, low_cnt_ff, a_cnt_ff;
  logic        h_prev_ff, v_prev_ff, p_prev_ff;
  wire         hrise = hsync & ~h_prev_ff;
  wire         vrise = vsync & ~v_prev_ff;
  // figures only settle after a whole frame, so first values are junk
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {h_cnt_ff, l_cnt_ff, low_cnt_ff, a_cnt_ff} <= '0;
      {line_len_ff, frame_lines_ff, low_len_ff, act_cnt_ff} <= '0;
      {h_prev_ff, v_prev_ff, p_prev_ff} <= '0;
    end else begin
      h_prev_ff  <= hsync;
      v_prev_ff  <= vsync;
      p_prev_ff  <= pclk;
      h_cnt_ff   <= hrise ? 16'h0001 : h_cnt_ff + 16'h0001;
      l_cnt_ff   <= (vrise ? 16'h0000 : l_cnt_ff) + 16'(hrise);
      low_cnt_ff <= pclk ? 16'h0000 : low_cnt_ff + 16'h0001;
      a_cnt_ff   <= vrise ? 16'h0000 : a_cnt_ff + 16'(data != 24'h000000);
      if (hrise) line_len_ff <= h_cnt_ff;
      if (vrise) frame_lines_ff <= l_cnt_ff;
      if (vrise) act_cnt_ff <= a_cnt_ff;
      if (pclk & ~p_prev_ff) low_len_ff <= low_cnt_ff;
    end
  end
endmodule

// ==== verification/testbench.sv ====
// self-checking bench for the display timing generator
`timescale 1ns/100ps
module testbench;
  logic aclk, aresetn, awv, wv, bry, arv, rry, pv;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rd;
  logic [1:0]  rs;
  wire  [31:0] rdata;
  wire  [23:0] bus;
  wire  [15:0] line_len, frame_lines, low_len, act_cnt;
  wire  [1:0]  bresp, rresp;
  wire         awr, wr, bv, arr, rv, pr, pclk, a1, hs, vs;
  int n_errors = 0;
  int checks_done = 0;
  sdt_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rry), .pix_valid(pv),
    .pix_ready(pr), .pix_data(24'h123456), .pixel_out_bus(bus),
    .pixel_clock_out(pclk), .aux_pin_one(a1), .aux_pin_two(hs), .aux_pin_three(vs));
  sdt_panel panel (.aclk(aclk), .aresetn(aresetn), .hsync(hs), .vsync(vs), .pclk(pclk),
    .data(bus), .line_len_ff(line_len), .frame_lines_ff(frame_lines),
    .low_len_ff(low_len), .act_cnt_ff(act_cnt));
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask
  // one bus transfer; waits on the slave answer, never on a fixed count
  task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    if (w) begin
      awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
    end else begin
      ara <= a; arv <= 1'b1; rry <= 1'b1;
    end
    for (int i = 0; i < 60; i++) begin
      @(posedge aclk);
      if (awv & awr) awv <= 1'b0;
      if (wv & wr) wv <= 1'b0;
      if (arv & arr) arv <= 1'b0;
      if (w & bv) begin
        rs = bresp; bry <= 1'b0; return;
      end
      if (!w & rv) begin
        rd = rdata; rs = rresp; rry <= 1'b0; return;
      end
    end
    chk(1'b0, "bus answer missing");
  endtask
  task automatic t_regs;
    axi(1'b0, sdt_pkg::ADDR_HTOTAL, 32'h0);
    chk(rd[11:0] === sdt_pkg::HTOTAL_RST && rs === sdt_pkg::RESP_OKAY, "htotal reset");
    axi(1'b0, 8'h34, 32'h0);
    chk(rs === sdt_pkg::RESP_SLVERR, "unmapped read accepted");
    chk(pr === 1'b1, "fifo not ready while empty");
  endtask
  // tiny frame: period 4 clocks, 10x6 geometry, 4x2 active, constant pixel
  task automatic t_frame;
    axi(1'b1, sdt_pkg::ADDR_HTOTAL, 32'd10);
    axi(1'b1, sdt_pkg::ADDR_HSYNC, 32'd2);
    axi(1'b1, sdt_pkg::ADDR_HLEAD, 32'd2);
    axi(1'b1, sdt_pkg::ADDR_HACT, 32'd4);
    axi(1'b1, sdt_pkg::ADDR_VTOTAL, 32'd6);
    axi(1'b1, sdt_pkg::ADDR_VSYNC, 32'd4);
    axi(1'b1, sdt_pkg::ADDR_VLEAD, 32'd1);
    axi(1'b1, sdt_pkg::ADDR_VACT, 32'd2);
    axi(1'b1, sdt_pkg::ADDR_CLKDIV, 32'h0102);
    axi(1'b1, sdt_pkg::ADDR_EDGE, 32'h0102);
    axi(1'b1, sdt_pkg::ADDR_CTRL, 32'h5);
    chk(rs === sdt_pkg::RESP_OKAY, "ctrl write refused");
    pv <= 1'b1;
    repeat (900) @(posedge aclk);
    chk(line_len === 16'd40, "line length");
    chk(frame_lines === 16'd6, "frame lines");
    chk(low_len === 16'd1, "clock low time");
    chk(act_cnt === 16'd32, "active cycles per frame");
    for (int i = 0; i < 300 && bus === 24'h0; i++) @(posedge aclk);
    chk(bus === 24'h123456, "rgb24 placement");
  endtask
  // one whole frame per layout: shown words and tear pin time, phase does not matter
  task automatic t_mode(input logic [31:0] ctrl, input logic [23:0] e0, input logic [23:0] e1);
    int n0 = 0;
    int n1 = 0;
    int nt = 0;
    int bad = 0;
    axi(1'b1, sdt_pkg::ADDR_CTRL, ctrl);
    repeat (2) @(posedge aclk);
    repeat (240) begin
      @(posedge aclk);
      n0 += int'(bus === e0);
      n1 += int'(bus === e1);
      nt += int'(a1 === 1'b1);
      bad += int'(bus !== 24'h0 && bus !== e0 && bus !== e1);
    end
    chk(bad == 0 && (e0 == e1 ? n0 == 32 : n0 == 16 && n1 == 16), "data layout");
    chk(nt == (ctrl[4] ? 160 : 0), "tear pin time");
  endtask
  task automatic report_and_stop;
    if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    {aresetn, awv, wv, bry, arv, rry, pv} = '0;
    {awa, ara, wd} = '0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_frame;
    t_mode(32'h01, 24'h0011aa, 24'h0011aa);
    t_mode(32'h03, 24'h004355, 24'h004355);
    t_mode(32'h19, 24'h003456, 24'h003456);
    axi(1'b1, sdt_pkg::ADDR_CLKDIV, 32'h0202);
    t_mode(32'h07, 24'h000056, 24'h000034);
    report_and_stop;
  end
  initial begin
    repeat (5000) @(posedge aclk);
    n_errors++;
    report_and_stop;
  end
endmodule
